// file: fac_consts.vh
`ifndef FAC_CONSTS_VH
`define FAC_CONSTS_VH

// register byte offsets
`define FAC_OFF_CTRL   8'h00
`define FAC_OFF_MODE   8'h04
`define FAC_OFF_XLO    8'h08
`define FAC_OFF_XHI    8'h0c
`define FAC_OFF_YLO    8'h10
`define FAC_OFF_YHI    8'h14
`define FAC_OFF_RLO    8'h18
`define FAC_OFF_RHI    8'h1c
`define FAC_OFF_ASTAT  8'h20
`define FAC_OFF_STKY   8'h24
`define FAC_OFF_BUSY   8'h28

// control fields
`define FAC_CTRL_START 3
`define FAC_OP_MAX     3'h1
`define FAC_OP_CLIP    3'h2
`define FAC_OP_DADD    3'h3
`define FAC_OP_DSUB    3'h4
`define FAC_OP_DCMP    3'h5
`define FAC_MODE_TRUNCATE_MODE_BIT 0

// arith status bit positions
`define FAC_AST_AZ     0
`define FAC_AST_AV     1
`define FAC_AST_AN     2
`define FAC_AST_AC     3
`define FAC_AST_AS     4
`define FAC_AST_AI     5
`define FAC_AST_CMSB   31

// sticky bit positions
`define FAC_STK_US     0
`define FAC_STK_VS     1
`define FAC_STK_IS     2
`define FAC_STK_OS     3

// timing
`define FAC_DBL_CYCLES 3'h7
`define FAC_SGL_CYCLES 3'h1

`endif

// file: fac_alu.v
// Function
// RULE1 - max returns the numerically larger single-precision operand
// RULE2 - max of +0 and -0 in any order returns +0
// RULE3 - any NaN source forces an all-ones result
// RULE4 - denormal sources are flushed to signed zero before use
// RULE5 - clip passes x if |x|<|y|, else |y| with x's sign
// RULE6 - max, clip, compare: invalid set on NaN source, else cleared
// RULE7 - negative follows result sign; carry and sign flags always clear
// RULE8 - max, clip: zero flag on signed zero result; overflow cleared
// RULE9 - invalid flag set also sets the sticky invalid flag
// RULE10 - double add sums two register-pair operands, normalized
// RULE11 - double subtract takes y away from x, normalized
// RULE12 - double ops take seven cycles, all updates at seventh end
// RULE13 - double add/sub round to nearest or truncate per mode bit
// RULE14 - overflow gives signed infinity or signed largest normal
// RULE15 - denormal result after rounding becomes signed zero
// RULE16 - add/sub invalid on NaN or opposite-signed infinities
// RULE17 - add/sub overflow when exponent above +1023, sets sticky
// RULE18 - add/sub zero flag on zero or exponent below -1022
// RULE19 - add/sub sticky underflow on denormal rounded result
// RULE20 - compare: zero flag if equal, negative if x smaller
// RULE21 - compare shifts the eight-bit history field right by one
// RULE22 - history msb loaded with one when x greater than y
// RULE23 - sticky overflow set whenever overflow flag is set
// RULE24 - compare writes no result, only status, sticky and history
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "fac_consts.vh"

module fac_alu
(
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg         o_pready,
   output reg  [31:0] o_prdata,
   output reg         o_pslverr,
   // status
   output reg         o_busy
);

localparam ST_IDLE = 2'b01;
localparam ST_RUN  = 2'b10;

////////////////////////////////////////////////////////////////////////
// flush denormal to signed zero, signed compare
function [63:0] flush64;
   input [63:0] v;
   begin
      flush64 = (v[62:52] == 11'h000) ? {v[63], 63'h0} : v; // [RULE4]
   end
endfunction
function [31:0] flush32;
   input [31:0] v;
   begin
      flush32 = (v[30:23] == 8'h00) ? {v[31], 31'h0} : v; // [RULE4]
   end
endfunction
// signed compare on flushed values; equal zeros never less
function lt_f;
   input        sa;
   input        sb;
   input [62:0] ma;
   input [62:0] mb;
   begin
      if (ma == 63'h0 && mb == 63'h0)
         lt_f = 1'b0;
      else if (sa != sb)
         lt_f = sa;
      else
         lt_f = sa ? (ma > mb) : (ma < mb);
   end
endfunction

////////////////////////////////////////////////////////////////////////
// registers
reg  [1:0]  st;
reg  [2:0]  cnt;
reg  [2:0]  op;
reg         truncate_mode_bit;
reg  [63:0] opx;
reg  [63:0] opy;
reg  [63:0] res;
reg  [31:0] astat;
reg  [3:0]  stky;
wire acc_w = i_psel & i_penable & o_pready & i_pwrite;
wire idle  = st[0];
wire is_dbl = (op == `FAC_OP_DADD) | (op == `FAC_OP_DSUB) |
              (op == `FAC_OP_DCMP);
wire [2:0] need = is_dbl ? `FAC_DBL_CYCLES : `FAC_SGL_CYCLES;
wire commit = st[1] & (cnt == need);
////////////////////////////////////////////////////////////////////////
// single-precision max and clip
reg  [31:0] sx;
reg  [31:0] sy;
reg         s_nan;
reg  [31:0] s_res;
always @*
begin
   sx = flush32(opx[31:0]);
   sy = flush32(opy[31:0]);
   s_nan = (&opx[30:23] & |opx[22:0]) | (&opy[30:23] & |opy[22:0]);
   if (s_nan)
      s_res = 32'hffffffff; // [RULE3]
   else if (op == `FAC_OP_MAX)
   begin
      if (sx[30:0] == 31'h0 && sy[30:0] == 31'h0)
         s_res = 32'h00000000; // [RULE2]
      else if (lt_f(sx[31], sy[31], {32'h0, sx[30:0]},
                    {32'h0, sy[30:0]}))
         s_res = sy; // [RULE1]
      else
         s_res = sx; // [RULE1]
   end
   else if (sx[30:0] < sy[30:0])
      s_res = sx; // [RULE5]
   else
      s_res = {sx[31], sy[30:0]}; // [RULE5]
end

////////////////////////////////////////////////////////////////////////
// double-precision add, subtract and compare
reg  [63:0]        dx;
reg  [63:0]        dy;
reg                nx, ny, ix, iy;
reg                sby;
reg                a_ge;
reg  [63:0]        big;
reg  [63:0]        sml;
reg                sg_b, sg_s;
reg  [55:0]        mb, ms, msh;
reg  [10:0]        dexp;
reg                stk;
reg  [56:0]        sum;
reg  [5:0]         p;
reg  [5:0]         sh;
reg  [55:0]        nrm;
reg                stk2;
reg  signed [12:0] ex;
reg                inc;
reg  [53:0]        man;
reg  [63:0]        d_res;
reg                d_ai, d_ov, d_uf, d_zr;
reg                c_eq, c_lt, c_gt;
integer            i;
always @*
begin
   dx = flush64(opx);
   dy = flush64(opy);
   nx = &opx[62:52] & |opx[51:0];
   ny = &opy[62:52] & |opy[51:0];
   ix = &opx[62:52] & ~|opx[51:0];
   iy = &opy[62:52] & ~|opy[51:0];
   sby = dy[63] ^ (op == `FAC_OP_DSUB); // [RULE11]
   a_ge = dx[62:0] >= dy[62:0];
   big  = a_ge ? dx : dy;
   sml  = a_ge ? dy : dx;
   sg_b = a_ge ? dx[63] : sby;
   sg_s = a_ge ? sby : dx[63];
   // three guard bits below the 52-bit fraction
   mb = {|big[62:52], big[51:0], 3'b000};
   ms = {|sml[62:52], sml[51:0], 3'b000};
   dexp = big[62:52] - sml[62:52];
   if (dexp > 11'd55)
   begin
      msh = 56'h0;
      stk = |ms;
   end
   else
   begin
      msh = ms >> dexp;
      stk = ((msh << dexp) != ms);
   end
   // sticky folded into the subtract keeps truncation honest
   if (sg_b == sg_s)
      sum = {1'b0, mb} + {1'b0, msh}; // [RULE10]
   else
      sum = {1'b0, mb} - {1'b0, msh} - {56'h0, stk}; // [RULE11]
   p = 6'd0;
   for (i = 0; i < 57; i = i + 1)
      if (sum[i])
         p = i[5:0];
   sh = 6'd55 - p;
   if (sum[56])
   begin
      nrm  = sum[56:1];
      stk2 = stk | sum[0];
      ex   = $signed({2'b00, big[62:52]}) + 13'sd1;
   end
   else
   begin
      nrm  = sum[55:0] << sh;
      stk2 = stk;
      ex   = $signed({2'b00, big[62:52]}) - $signed({7'h00, sh});
   end
   inc = ~truncate_mode_bit & nrm[2] & (nrm[1] | nrm[0] | stk2 | nrm[3]); // [RULE13]
   man = {1'b0, nrm[55:3]} + {53'h0, inc};
   if (man[53])
   begin
      man = {1'b0, man[53:1]};
      ex  = ex + 13'sd1;
   end
   d_ai = nx | ny | (ix & iy & (dx[63] != sby)); // [RULE16]
   d_ov = 1'b0;
   d_uf = 1'b0;
   d_zr = 1'b0;
   if (d_ai)
      d_res = 64'hffffffffffffffff; // [RULE3]
   else if (ix | iy)
      d_res = {sg_b, 11'h7ff, 52'h0};
   else if (sum == 57'h0)
   begin
      d_res = {sg_b & sg_s, 63'h0};
      d_zr  = 1'b1; // [RULE18]
   end
   else if (ex < 13'sd1)
   begin
      d_res = {sg_b, 63'h0}; // [RULE15]
      d_zr  = 1'b1; // [RULE18]
      d_uf  = 1'b1; // [RULE19]
   end
   else if (ex > 13'sd2046)
   begin
      d_ov = 1'b1; // [RULE17]
      if (truncate_mode_bit)
         d_res = {sg_b, 11'h7fe, 52'hfffffffffffff}; // [RULE14]
      else
         d_res = {sg_b, 11'h7ff, 52'h0}; // [RULE14]
   end
   else
      d_res = {sg_b, ex[10:0], man[51:0]};
   c_eq = ~(nx | ny) & (dx == dy | (dx[62:0] == 63'h0 &&
                                    dy[62:0] == 63'h0));
   c_lt = ~(nx | ny) & lt_f(dx[63], dy[63], dx[62:0], dy[62:0]);
   c_gt = ~(nx | ny) & ~c_eq & ~c_lt;
end

////////////////////////////////////////////////////////////////////////
// flags of the finishing operation
reg        f_ai, f_an, f_az, f_av, f_uf;
reg [63:0] f_res;
always @*
begin
   f_res = res;
   f_uf  = 1'b0;
   f_av  = 1'b0; // [RULE8]
   if (op == `FAC_OP_DCMP)
   begin
      f_ai = nx | ny; // [RULE6]
      f_az = c_eq; // [RULE20]
      f_an = c_lt; // [RULE20]
   end
   else if (is_dbl)
   begin
      f_res = d_res;
      f_ai  = d_ai;
      f_an  = ~d_ai & d_res[63]; // [RULE7]
      f_az  = d_zr;
      f_av  = d_ov; // [RULE17]
      f_uf  = d_uf;
   end
   else
   begin
      f_res = {res[63:32], s_res};
      f_ai  = s_nan; // [RULE6]
      f_an  = ~s_nan & s_res[31]; // [RULE7]
      f_az  = ~s_nan & (s_res[30:0] == 31'h0); // [RULE8]
   end
end

////////////////////////////////////////////////////////////////////////
// sequencing and register file
always @(posedge i_clk)
begin
   if (!i_rst_n)
   begin
      st     <= ST_IDLE;
      cnt    <= 3'h0;
      op     <= 3'h0;
      truncate_mode_bit  <= 1'b0;
      opx    <= 64'h0;
      opy    <= 64'h0;
      res    <= 64'h0;
      astat  <= 32'h0;
      stky   <= 4'h0;
      o_busy <= 1'b0;
   end
   else
   begin
      // operands frozen while busy so the datapath sees stable inputs
      if (acc_w && idle)
      begin
         case (i_paddr)
            `FAC_OFF_MODE: truncate_mode_bit <= i_pwdata[`FAC_MODE_TRUNCATE_MODE_BIT];
            `FAC_OFF_XLO:  opx[31:0]  <= i_pwdata;
            `FAC_OFF_XHI:  opx[63:32] <= i_pwdata;
            `FAC_OFF_YLO:  opy[31:0]  <= i_pwdata;
            `FAC_OFF_YHI:  opy[63:32] <= i_pwdata;
            default:       op <= op;
         endcase
      end
      case (st)
         ST_IDLE:
         begin
            if (acc_w && i_paddr == `FAC_OFF_CTRL &&
                i_pwdata[`FAC_CTRL_START] &&
                i_pwdata[2:0] >= `FAC_OP_MAX &&
                i_pwdata[2:0] <= `FAC_OP_DCMP)
            begin
               op     <= i_pwdata[2:0];
               cnt    <= 3'h1;
               st     <= ST_RUN;
               o_busy <= 1'b1;
            end
         end
         ST_RUN:
         begin
            if (commit) // [RULE12]
            begin
               st     <= ST_IDLE;
               o_busy <= 1'b0;
            end
            else
               cnt <= cnt + 3'h1;
         end
         default:
         begin
            st     <= ST_IDLE;
            o_busy <= 1'b0;
         end
      endcase
      if (commit)
      begin
         if (op != `FAC_OP_DCMP)
            res <= f_res; // [RULE24]
         astat[`FAC_AST_AZ] <= f_az;
         astat[`FAC_AST_AV] <= f_av;
         astat[`FAC_AST_AN] <= f_an;
         astat[`FAC_AST_AC] <= 1'b0; // [RULE7]
         astat[`FAC_AST_AS] <= 1'b0; // [RULE7]
         astat[`FAC_AST_AI] <= f_ai;
         if (op == `FAC_OP_DCMP)
            astat[31:24] <= {c_gt, astat[31:25]}; // [RULE21] [RULE22]
      end
      // write one to clear; a same-cycle set wins
      stky <= (stky & ~((acc_w && i_paddr == `FAC_OFF_STKY) ?
                        i_pwdata[3:0] : 4'h0))
              | {1'b0,
                 commit & f_ai, // [RULE9]
                 commit & f_av, // [RULE23]
                 commit & f_uf}; // [RULE19]
   end
end

////////////////////////////////////////////////////////////////////////
// apb answer: ready in the first access cycle, registered data
always @(posedge i_clk)
begin
   if (!i_rst_n)
   begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
   end
   else
   begin
      o_pready  <= i_psel & ~i_penable & ~o_pready;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable)
      begin
         case (i_paddr)
            `FAC_OFF_CTRL:  o_prdata <= {29'h0, op};
            `FAC_OFF_MODE:  o_prdata <= {31'h0, truncate_mode_bit};
            `FAC_OFF_XLO:   o_prdata <= opx[31:0];
            `FAC_OFF_XHI:   o_prdata <= opx[63:32];
            `FAC_OFF_YLO:   o_prdata <= opy[31:0];
            `FAC_OFF_YHI:   o_prdata <= opy[63:32];
            `FAC_OFF_RLO:   o_prdata <= res[31:0];
            `FAC_OFF_RHI:   o_prdata <= res[63:32];
            `FAC_OFF_ASTAT: o_prdata <= astat;
            `FAC_OFF_STKY:  o_prdata <= {28'h0, stky};
            `FAC_OFF_BUSY:  o_prdata <= {31'h0, o_busy};
            default:
            begin
               o_prdata  <= 32'h0;
               o_pslverr <= 1'b1;
            end
         endcase
      end
   end
end

endmodule // fac_alu

// file: fac_alu_chk.sv
`timescale 1ns/1ns
module fac_alu_chk
(
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // apb
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   input  wire        o_pready,
   input  wire [31:0] o_prdata,
   input  wire        o_pslverr,
   // status
   input  wire        o_busy
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   wire go = i_psel && i_penable && o_pready && i_pwrite &&
             i_paddr == 8'h00 && i_pwdata[3] && !o_busy;
   sequence s_dbl_go;
      go && i_pwdata[2:0] >= 3'h3 && i_pwdata[2:0] <= 3'h5;
   endsequence
   sequence s_sgl_go;
      go && (i_pwdata[2:0] == 3'h1 || i_pwdata[2:0] == 3'h2);
   endsequence
   sequence s_seven_busy;
      o_busy [*7] ##1 !o_busy;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   AST_DBL_LAT: assert property (s_dbl_go |=> s_seven_busy)
      else $error("double op busy span wrong");
   AST_SGL_LAT: assert property (s_sgl_go |=> o_busy ##1 !o_busy)
      else $error("single op busy span wrong");
   AST_BUSY_SRC: assert property ($rose(o_busy) |-> $past(go))
      else $error("busy rose without a start");
   AST_BUSY_MAX: assert property (o_busy [*7] |=> !o_busy)
      else $error("busy longer than seven cycles");
   AST_RDY_PULSE: assert property (o_pready |=> !o_pready)
      else $error("ready longer than one cycle");
   AST_RDY_ONLY: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access phase");
   AST_ERR_RDY: assert property
      (o_pslverr |-> o_pready && !o_prdata)
      else $error("error without ready or with data");
   AST_RDY_ACC: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready in access phase");
endmodule // fac_alu_chk

// file: fac_apb_mst.sv
`timescale 1ns/1ns
module fac_apb_mst
(
   // clock
   input  wire        i_clk,
   // apb answer
   input  wire        i_pready,
   input  wire [31:0] i_prdata,
   input  wire        i_pslverr,
   // apb request
   output reg         o_psel = 1'b0,
   output reg         o_penable = 1'b0,
   output reg         o_pwrite = 1'b0,
   output reg  [7:0]  o_paddr = 8'h00,
   output reg  [31:0] o_pwdata = 32'h0
);
   // entered right after a rising edge; leaves one edge after release
   task xfer(input w, input [7:0] a, input [31:0] d,
             output [31:0] r, output e);
      begin
         o_psel <= 1'b1;
         o_pwrite <= w;
         o_paddr <= a;
         o_pwdata <= d;
         @(posedge i_clk);
         o_penable <= 1'b1;
         @(posedge i_clk);
         while (i_pready !== 1'b1)
         begin
            @(posedge i_clk);
         end
         r = i_prdata;
         e = i_pslverr;
         o_psel <= 1'b0;
         o_penable <= 1'b0;
         // scrambled after release so nothing leans on stale values
         o_paddr <= ~a;
         o_pwdata <= ~d;
         @(posedge i_clk);
      end
   endtask
endmodule // fac_apb_mst

// file: float_alu_minmax_clip_dbl_addsub_cmp_tb.sv
`timescale 1ns/1ns
`include "fac_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module float_alu_minmax_clip_dbl_addsub_cmp_tb;
   reg         i_clk = 1'b0;
   reg         i_rst_n = 1'b0;
   wire        psel, penable, pwrite, pready, pslverr, busy;
   wire [7:0]  paddr;
   wire [31:0] pwdata, prdata;
   integer     fails = 0;
   integer     cmp_count = 0;
   integer     seed = 32'h2fc919f8;
   integer     i;
   reg  [31:0] rd, m_rlo = 0, m_rhi = 0, m_ast = 0, m_stk = 0;
   reg         er, mtr = 1'b0;
   reg  [2:0]  m_op = 3'h0;
   always #50 i_clk = ~i_clk;
   fac_apb_mst mst (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
      .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
   fac_alu uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .o_busy(busy));
   ////////////////////////////////////////////////////////////////////////////
   task wr(input [7:0] a, input [31:0] d);
      mst.xfer(1'b1, a, d, rd, er);
   endtask
   task rdc(input [7:0] a, input [31:0] e);
      begin
         mst.xfer(1'b0, a, 32'h0, rd, er);
         `CHK(rd, e)
      end
   endtask
   function [63:0] fl(input [63:0] v, input d);
      if (d)
         fl = v[62:52] == 0 ? {v[63], 63'h0} : v;
      else
         fl = v[30:23] == 0 ? {32'h0, v[31], 31'h0} : v;
   endfunction
   function nan(input [63:0] v, input d);
      nan = d ? &v[62:52] && |v[51:0] : &v[30:23] && |v[22:0];
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic run_op(input [2:0] op, input [63:0] x, input [63:0] y);
      reg [63:0] a, b, r;
      reg        inv, ovf, zr, ng, und, gt, dbl;
      integer    ka, kb;
      real       ra, rb, rs, re;
      begin
         dbl = op >= `FAC_OP_DADD;
         wr(`FAC_OFF_XLO, x[31:0]);
         wr(`FAC_OFF_XHI, x[63:32]);
         wr(`FAC_OFF_YLO, y[31:0]);
         wr(`FAC_OFF_YHI, y[63:32]);
         wr(`FAC_OFF_CTRL, {28'h0, 1'b1, op});
         m_op = op;
         if (dbl)
         begin
            rdc(`FAC_OFF_BUSY, 32'h1);
            rdc(`FAC_OFF_RLO, m_rlo);
         end
         rd = 32'h1;
         while (rd[0] !== 1'b0)
            mst.xfer(1'b0, `FAC_OFF_BUSY, 32'h0, rd, er);
         a = fl(x, dbl);
         b = fl(y, dbl);
         {inv, ovf, zr, ng, und, gt} = 6'h0;
         r = {64{1'b1}};
         if (nan(a, dbl) || nan(b, dbl))
            inv = 1'b1;
         else if (!dbl)
         begin
            ka = a[31] ? -a[30:0] : a[30:0];
            kb = b[31] ? -b[30:0] : b[30:0];
            if (op == `FAC_OP_MAX)
               r = ka > kb ? a : kb > ka ? b : a & b;
            else
               r = a[30:0] < b[30:0] ? a : {a[31], b[30:0]};
            zr = r[30:0] == 0;
            ng = r[31];
         end
         else
         begin
            if (op == `FAC_OP_DSUB)
               b[63] = ~b[63];
            ra = $bitstoreal(a);
            rb = $bitstoreal(b);
            if (op == `FAC_OP_DCMP)
               {zr, ng, gt} = {ra == rb, ra < rb, ra > rb};
            else if (&a[62:52] && &b[62:52] && a[63] != b[63])
               inv = 1'b1;
            else
            begin
               r = $realtobits(ra + rb);
               ovf = &r[62:52] && !(&a[62:52]) && !(&b[62:52]);
               // exact residue of the rounded sum tells if truncation steps
               rs = $bitstoreal(r) - ra;
               re = (ra - ($bitstoreal(r) - rs)) + (rb - rs);
               if (mtr && !ovf && re != 0.0 && (re < 0.0) != r[63])
                  r = r - 64'h1;
               if (ovf && mtr)
                  r = {r[63], 11'h7fe, {52{1'b1}}};
               und = r[62:52] == 0 && r[51:0] != 0;
               if (und)
                  r = {r[63], 63'h0};
               zr = r[62:0] == 0;
               ng = r[63];
            end
         end
         if (op == `FAC_OP_DCMP)
            m_ast[31:24] = {gt, m_ast[31:25]};
         m_ast[5:0] = {inv, 2'b00, ng, ovf, zr};
         m_stk[2:0] = m_stk[2:0] | {inv, ovf, und};
         if (op != `FAC_OP_DCMP)
            m_rlo = r[31:0];
         if (dbl && op != `FAC_OP_DCMP)
            m_rhi = r[63:32];
         rdc(`FAC_OFF_RLO, m_rlo);
         rdc(`FAC_OFF_RHI, m_rhi);
         rdc(`FAC_OFF_ASTAT, m_ast);
         rdc(`FAC_OFF_STKY, m_stk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      begin
         $display("mismatches %0d of %0d compares", fails, cmp_count);
         if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      #2000000;
      fails++;
      summarize;
   end
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rdc(`FAC_OFF_MODE, 32'h0);
      mst.xfer(1'b0, 8'h40, 32'h0, rd, er);
      `CHK({er, rd}, 33'h1_0000_0000)
      wr(`FAC_OFF_RLO, 32'h1234);
      rdc(`FAC_OFF_RLO, 32'h0);
      run_op(`FAC_OP_MAX, 64'h0, 64'h80000000);
      run_op(`FAC_OP_MAX, 64'h80000000, 64'h0);
      run_op(`FAC_OP_MAX, 64'hbf800000, 64'hc0000000);
      run_op(`FAC_OP_MAX, 64'h80000001, 64'h0);
      run_op(`FAC_OP_MAX, 64'h7fc00000, 64'h3f800000);
      run_op(`FAC_OP_CLIP, 64'hc0400000, 64'h3f800000);
      run_op(`FAC_OP_CLIP, 64'h3f000000, 64'hbf800000);
      run_op(`FAC_OP_CLIP, 64'h3f000000, 64'h7f800001);
      run_op(`FAC_OP_DADD, 64'h7fefffffffffffff, 64'h7fefffffffffffff);
      run_op(`FAC_OP_DSUB, 64'h7ff0000000000000, 64'h7ff0000000000000);
      run_op(`FAC_OP_DADD, 64'h0010000000000001, 64'h8010000000000000);
      run_op(`FAC_OP_DCMP, 64'h3ff0000000000000, 64'h3ff0000000000000);
      run_op(`FAC_OP_DCMP, 64'h3ff0000000000000, 64'h4000000000000000);
      run_op(`FAC_OP_DCMP, 64'h4000000000000000, 64'h3ff0000000000000);
      run_op(`FAC_OP_DCMP, 64'h7ff8000000000000, 64'h0);
      wr(`FAC_OFF_MODE, 32'h1);
      mtr = 1'b1;
      run_op(`FAC_OP_DADD, 64'h7fefffffffffffff, 64'h7fefffffffffffff);
      run_op(`FAC_OP_DSUB, 64'h4008000000000000, 64'h3ff0000000000000);
      run_op(`FAC_OP_DADD, 64'h3ff0000000000000,
             64'h3ca8000000000000);
      wr(`FAC_OFF_MODE, 32'h0);
      mtr = 1'b0;
      // random pass mostly nearest; the last eight truncate
      for (i = 0; i < 32; i++)
      begin
         if (i == 24)
         begin
            wr(`FAC_OFF_MODE, 32'h1);
            mtr = 1'b1;
         end
         run_op(3'h3 + i % 3, {$random(seed), $random(seed)},
                {$random(seed), $random(seed)});
      end
      // op code outside the decoded set must not start anything
      wr(`FAC_OFF_CTRL, 32'hf);
      rdc(`FAC_OFF_CTRL, {29'h0, m_op});
      wr(`FAC_OFF_STKY, 32'hf);
      m_stk = 32'h0;
      rdc(`FAC_OFF_STKY, m_stk);
      summarize;
   end
endmodule // float_alu_minmax_clip_dbl_addsub_cmp_tb
bind fac_alu fac_alu_chk chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
   .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_busy(o_busy));
